// [sfts_port.sv]
`timescale 1ns/10ps
module sfts_port
    import sfts_pkg::*;
#(
    parameter int LANES = 4,
    parameter int ADDR_W = 21
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic loadOrStepSelect,
    input wire logic clockQualifyN,
    input wire logic chipSelectOneN,
    input wire logic chipSelectTwo,
    input wire logic chipSelectThreeN,
    input wire logic writeN,
    input wire logic [LANES-1:0] byteLaneWriteN,
    input wire logic outputEnableN,
    input wire logic sleepRequest,
    input wire logic burstOrderStrap,
    // Data pins
    input wire logic [LANES*BYTE_W-1:0] dqIn,
    output logic [LANES*BYTE_W-1:0] dqOut,
    output logic dqOe,
    // Parity pins
    input wire logic [LANES-1:0] parityLanesIn,
    output logic [LANES-1:0] parityLanesOut,
    output logic parityLanesOe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sfts_op_t op_q;
    sfts_op_t op_d;
    logic first_q;
    logic first_d;
    logic drive_q;
    logic drive_d;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [BURST_W-1:0] cnt_q;
    logic [BURST_W-1:0] cnt_d;
    logic [ADDR_W-1:0] wrAddr_q;
    logic [ADDR_W-1:0] wrAddr_d;
    logic [LANES-1:0] wrBwN_q;
    logic [LANES-1:0] wrBwN_d;
    logic interleave_q;
    logic interleave_d;

    logic qualified;
    logic selected;
    logic loading;
    logic stepping;
    logic [BURST_W-1:0] cntNext;
    logic [BURST_W-1:0] lowNext;
    logic [ADDR_W-1:0] accAddr;
    logic memRdEn;
    logic memWrEn;
    logic [LANES*LANE_W-1:0] memRdData;
    logic [LANES*LANE_W-1:0] memWrData;

    // ------------------------------------------------------------
    // Edge qualification and select decode
    // ------------------------------------------------------------
    // qualified edge only
    assign qualified = !clockQualifyN && !sleepRequest;
    assign selected = !chipSelectOneN && chipSelectTwo && !chipSelectThreeN;
    assign loading = qualified && !loadOrStepSelect;
    assign stepping = qualified && loadOrStepSelect && (op_q != OP_DESEL);

    // ------------------------------------------------------------
    // Burst addressing
    // ------------------------------------------------------------
    // two-bit wrap
    assign cntNext = BURST_W'(cnt_q + BURST_STEP);

    sfts_burst uBurst (
        .startLow(base_q[BURST_W-1:0]),
        .count(cntNext),
        .interleave(interleave_q),
        .lowAddr(lowNext)
    );

    always_comb begin
        if (loading) begin
            accAddr = addr;
        end else begin
            accAddr = {base_q[ADDR_W-1:BURST_W], lowNext};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        op_d = op_q;
        first_d = first_q;
        drive_d = drive_q;
        base_d = base_q;
        cnt_d = cnt_q;
        wrAddr_d = wrAddr_q;
        wrBwN_d = wrBwN_q;
        // Strap is caught while reset is held, then left alone
        interleave_d = interleave_q;
        if (rst) begin
            interleave_d = (burstOrderStrap != STRAP_LINEAR);
        end
        if (loading) begin
            if (selected) begin
                base_d = addr;
                cnt_d = BURST_ZERO;
                if (writeN) begin
                    op_d = OP_READ;
                end else begin
                    op_d = OP_WRITE;
                end
            end else begin
                op_d = OP_DESEL;
            end
        end else if (stepping) begin
            cnt_d = cntNext;
        end
        if (qualified) begin
            wrAddr_d = accAddr;
            wrBwN_d = byteLaneWriteN;
            first_d = (op_q == OP_DESEL) && (op_d != OP_DESEL);
            drive_d = (op_d == OP_READ) && !first_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= OP_DESEL;
            first_q <= 1'b0;
            drive_q <= DRIVE_RESET;
            base_q <= '0;
            cnt_q <= BURST_ZERO;
            wrAddr_q <= '0;
            wrBwN_q <= '1;
        end else begin
            op_q <= op_d;
            first_q <= first_d;
            drive_q <= drive_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            wrAddr_q <= wrAddr_d;
            wrBwN_q <= wrBwN_d;
        end
        interleave_q <= interleave_d;
    end

    // ------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------
    // read at edge, data out after it
    assign memRdEn = (loading && selected && writeN)
        || (stepping && (op_q == OP_READ));
    // write data taken at next edge
    assign memWrEn = qualified && (op_q == OP_WRITE) && !rst;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gPack
            // parity rides in its byte lane
            assign memWrData[g*LANE_W +: LANE_W] =
                {parityLanesIn[g], dqIn[g*BYTE_W +: BYTE_W]};
            assign dqOut[g*BYTE_W +: BYTE_W] =
                memRdData[g*LANE_W +: BYTE_W];
            assign parityLanesOut[g] = memRdData[g*LANE_W + BYTE_W];
        end
    endgenerate

    sfts_mem #(
        .LANES(LANES),
        .AW(ADDR_W)
    ) uMem (
        .clk(clk),
        .rdEn(memRdEn),
        .rdAddr(accAddr),
        .rdData(memRdData),
        .wrEn(memWrEn),
        .wrAddr(wrAddr_q),
        .wrLaneEn(~wrBwN_q),
        .wrData(memWrData)
    );

    // ------------------------------------------------------------
    // Pin direction
    // ------------------------------------------------------------
    // Enable left combinational so output enable stays asynchronous
    // async gate
    assign dqOe = drive_q && !outputEnableN && !sleepRequest;
    assign parityLanesOe = dqOe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sLoadSel;
        qualified && !loadOrStepSelect && selected;
    endsequence

    sequence sLoadDesel;
        qualified && !loadOrStepSelect && !selected;
    endsequence

    sequence sStep;
        qualified && loadOrStepSelect && (op_q != OP_DESEL);
    endsequence

    sequence sEmerge;
        (op_q == OP_DESEL) ##0 sLoadSel;
    endsequence

    AST_STEP_COUNT:
    assert property (sStep |=> cnt_q == BURST_W'($past(cnt_q) + 2'h1))
        else $error("burst counter did not advance");

    AST_LOAD_ADDR:
    assert property (sLoadSel |=> (base_q == $past(addr))
        && (cnt_q == BURST_ZERO))
        else $error("new address not loaded");

    AST_FREEZE:
    assert property (clockQualifyN |=> $stable(op_q) && $stable(cnt_q)
        && $stable(base_q) && $stable(drive_q))
        else $error("state moved on unqualified edge");

    AST_DESELECT:
    assert property (sLoadDesel |=> (op_q == OP_DESEL) ##0 !dqOe)
        else $error("deselect not taken");

    AST_EMERGE_MASK:
    assert property (sEmerge |=> !dqOe && first_q)
        else $error("outputs driven when emerging");

    AST_WRITE_MASK:
    assert property ((op_q == OP_WRITE) |-> !dqOe && !parityLanesOe)
        else $error("outputs driven in write data phase");

    AST_OE_HIGH:
    assert property (outputEnableN |-> !dqOe && !parityLanesOe)
        else $error("outputs driven with output enable high");

    AST_READ_DRIVE:
    assert property ((sLoadSel ##0 writeN ##1 (op_q == OP_READ)
        && !first_q && !outputEnableN && !sleepRequest)
        |-> dqOe && parityLanesOe)
        else $error("read data not driven");

    AST_SLEEP_HOLD:
    assert property (sleepRequest |-> !dqOe ##1 $stable(op_q)
        && $stable(cnt_q))
        else $error("activity during sleep");

    // Stalls may sit inside a write, so compare one qualified edge
    AST_WRITE_LANES:
    assert property ((qualified && (op_q == OP_WRITE))
        |-> memWrEn ##1 (wrBwN_q == $past(byteLaneWriteN)))
        else $error("write lanes not from sampled selects");

endmodule

// [sfts_pkg.sv]
package sfts_pkg;

    // ------------------------------------------------------------
    // Lane layout
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int LANE_W = BYTE_W + 1;
    localparam int BURST_W = 2;

    // ------------------------------------------------------------
    // Reset and strap values
    // ------------------------------------------------------------
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic STRAP_LINEAR = 1'b0;
    localparam logic DRIVE_RESET = 1'b0;

    // ------------------------------------------------------------
    // Operation held for the current data phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_DESEL = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } sfts_op_t;

endpackage

// [sfts_burst.sv]
`timescale 1ns/10ps
module sfts_burst
    import sfts_pkg::*;
(
    // Burst state
    input wire logic [BURST_W-1:0] startLow,
    input wire logic [BURST_W-1:0] count,
    input wire logic interleave,
    // Low address bits
    output logic [BURST_W-1:0] lowAddr
);

    // Only the low bits move, so a burst wraps inside four words
    always_comb begin
        if (interleave) begin
            lowAddr = startLow ^ count;
        end else begin
            lowAddr = BURST_W'(startLow + count);
        end
    end

endmodule

// [sfts_mem.sv]
`timescale 1ns/10ps
module sfts_mem
    import sfts_pkg::*;
#(
    parameter int LANES = 4,
    parameter int AW = 21
)
(
    // Clock
    input wire logic clk,
    // Read port
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [LANES*LANE_W-1:0] rdData,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [LANES-1:0] wrLaneEn,
    input wire logic [LANES*LANE_W-1:0] wrData
);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            logic [LANE_W-1:0] store [0:(2**AW)-1];
            logic [LANE_W-1:0] rdLane_d;
            logic [LANE_W-1:0] rdLane_q;
            logic laneWr;

            assign laneWr = wrEn && wrLaneEn[g];

            // Bypass keeps a read of the word being written coherent
            always_comb begin
                rdLane_d = rdLane_q;
                if (rdEn) begin
                    if (laneWr && (wrAddr == rdAddr)) begin
                        rdLane_d = wrData[g*LANE_W +: LANE_W];
                    end else begin
                        rdLane_d = store[rdAddr];
                    end
                end
            end

            always_ff @(posedge clk) begin
                rdLane_q <= rdLane_d;
                if (laneWr) begin
                    store[wrAddr] <= wrData[g*LANE_W +: LANE_W];
                end
            end

            assign rdData[g*LANE_W +: LANE_W] = rdLane_q;
        end
    endgenerate

endmodule

// [sfts_ctrl.sv]
`timescale 1ns/10ps
module sfts_ctrl
    import sfts_pkg::*;
#(
    parameter int LANES = 4,
    parameter int ADDR_W = 21
)
(
    // Clock
    input wire logic clk,
    // Command
    output logic [ADDR_W-1:0] addr,
    output logic loadOrStepSelect,
    output logic clockQualifyN,
    output logic chipSelectOneN,
    output logic chipSelectTwo,
    output logic chipSelectThreeN,
    output logic writeN,
    output logic [LANES-1:0] byteLaneWriteN,
    output logic outputEnableN,
    output logic sleepRequest,
    // Write data
    output logic [LANES*BYTE_W-1:0] dqIn,
    output logic [LANES-1:0] parityLanesIn
);
    initial begin
        addr = '0;
        loadOrStepSelect = 1'b0;
        clockQualifyN = 1'b0;
        {chipSelectOneN, chipSelectTwo, chipSelectThreeN} = 3'h7;
        writeN = 1'b1;
        byteLaneWriteN = '1;
        outputEnableN = 1'b0;
        sleepRequest = 1'b0;
        dqIn = '0;
        parityLanesIn = '0;
    end

    // ------------------------------------------------------------
    // One qualified cycle; op is {step, write}
    // ------------------------------------------------------------
    task automatic cyc(input logic [1:0] op, input logic [2:0] cs,
        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
        input logic hd, input logic [LANES*LANE_W-1:0] d);
        @(posedge clk);
        clockQualifyN <= 1'b0;
        outputEnableN <= 1'b0;
        sleepRequest <= 1'b0;
        loadOrStepSelect <= op[1];
        writeN <= !op[0];
        {chipSelectOneN, chipSelectTwo, chipSelectThreeN} <= cs;
        addr <= a;
        byteLaneWriteN <= bw;
        // Released bus never keeps its last value
        if (hd) begin
            {parityLanesIn, dqIn} <= d;
        end else begin
            {parityLanesIn, dqIn} <= ~{parityLanesIn, dqIn};
        end
    endtask

    // Stalled edge: address, load/step and write scrambled so a taken edge shows
    task automatic pins(input logic cq, input logic oe, input logic slp);
        @(posedge clk);
        clockQualifyN <= cq;
        outputEnableN <= oe;
        sleepRequest <= slp;
        addr <= ~addr;
        loadOrStepSelect <= ~loadOrStepSelect;
        writeN <= ~writeN;
    endtask
endmodule

// [sfts_port_tb.sv]
`timescale 1ns/10ps
module sfts_port_tb;
    import sfts_pkg::*;
    localparam int LANES = 4;
    localparam int AW = 21;
    localparam int DW = LANES * LANE_W;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DES = 3'h7;
    localparam logic [1:0] RD = 2'h0;
    localparam logic [1:0] WR = 2'h1;
    localparam logic [1:0] SR = 2'h2;
    localparam logic [1:0] SW = 2'h3;
    logic clk, rst, strap, ldStep, cqN, cs1N, cs2, cs3N, wrN, oeN, sleep;
    logic [AW-1:0] addr;
    logic [LANES-1:0] bwN, parIn, parOut;
    logic [LANES*BYTE_W-1:0] dqIn, dqOut;
    logic dqOe, parOe, ps;
    int err_total, num_checks;

    sfts_port #(.LANES(LANES), .ADDR_W(AW)) dut (.clk(clk), .rst(rst),
        .addr(addr), .loadOrStepSelect(ldStep), .clockQualifyN(cqN),
        .chipSelectOneN(cs1N), .chipSelectTwo(cs2), .chipSelectThreeN(cs3N),
        .writeN(wrN), .byteLaneWriteN(bwN), .outputEnableN(oeN),
        .sleepRequest(sleep), .burstOrderStrap(strap), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .parityLanesIn(parIn),
        .parityLanesOut(parOut), .parityLanesOe(parOe));

    sfts_ctrl #(.LANES(LANES), .ADDR_W(AW)) ctl (.clk(clk), .addr(addr),
        .loadOrStepSelect(ldStep), .clockQualifyN(cqN),
        .chipSelectOneN(cs1N), .chipSelectTwo(cs2), .chipSelectThreeN(cs3N),
        .writeN(wrN), .byteLaneWriteN(bwN), .outputEnableN(oeN),
        .sleepRequest(sleep), .dqIn(dqIn), .parityLanesIn(parIn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] pat(input logic [3:0] k);
        return {k, {8{k ^ 4'hA}}};
    endfunction

    function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o,
        input logic [DW-1:0] n, input logic [LANES-1:0] bw);
        mrg = o;
        for (int g = 0; g < LANES; g++) begin
            if (!bw[g]) begin
                mrg[8*g +: 8] = n[8*g +: 8];
                mrg[LANES*BYTE_W+g] = n[LANES*BYTE_W+g];
            end
        end
    endfunction

    task automatic chkData(input logic [DW-1:0] e);
        num_checks++;
        if ({parOut, dqOut} !== e) begin
            err_total++;
            $display("FAIL %0t data %h expected %h", $time,
                {parOut, dqOut}, e);
        end
    endtask

    task automatic chkOe(input logic e);
        num_checks++;
        if (dqOe !== e || parOe !== e) begin
            err_total++;
            $display("FAIL %0t drive enable %b expected %b", $time, dqOe, e);
        end
    endtask

    task automatic doReset(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        repeat (6) @(posedge clk);
        #1 chkOe(1'b0);
        @(posedge clk);
        rst <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic tWriteRead;
        ctl.cyc(WR, SEL, 21'h10, 4'h0, 1'b0, '0);
        ctl.cyc(WR, SEL, 21'h11, 4'h0, 1'b1, pat(1));
        #1 chkOe(1'b0);
        ctl.cyc(WR, SEL, 21'h11, 4'h5, 1'b1, pat(2));
        #1 chkOe(1'b0);
        ctl.cyc(RD, SEL, 21'h10, 4'h0, 1'b1, pat(3));
        #1 chkOe(1'b0);
        ctl.cyc(RD, SEL, 21'h11, 4'hF, 1'b0, '0);
        #1 chkData(pat(1));
        chkOe(1'b1);
        ctl.cyc(RD, DES, '0, 4'hF, 1'b0, '0);
        #1 chkData(mrg(pat(2), pat(3), 4'h5));
    endtask

    task automatic tBurst;
        ctl.cyc(WR, SEL, 21'h23, 4'h0, 1'b0, '0);
        for (int k = 0; k < 3; k++) begin
            ctl.cyc(SW, SEL, '0, 4'h0, 1'b1, pat(4'((k + 3) % 4)));
        end
        ctl.cyc(RD, SEL, 21'h22, 4'hF, 1'b1, pat(2));
        for (int k = 0; k < 4; k++) begin
            ctl.cyc(SR, SEL, '0, 4'hF, 1'b0, '0);
            #1 chkData(pat(4'((k + 2) % 4)));
        end
        ctl.cyc(RD, DES, '0, 4'hF, 1'b0, '0);
        doReset(1'b1);
        ctl.cyc(RD, SEL, 21'h21, 4'hF, 1'b0, '0);
        for (int k = 0; k < 4; k++) begin
            ctl.cyc(SR, SEL, '0, 4'hF, 1'b0, '0);
            #1 chkData(pat(4'(1 ^ k)));
            chkOe(k > 0);
        end
    endtask

    task automatic tStall;
        ctl.cyc(RD, SEL, 21'h20, 4'hF, 1'b0, '0);
        ctl.pins(1'b1, 1'b0, 1'b0);
        #1 chkData(pat(0));
        ctl.pins(1'b1, 1'b1, 1'b0);
        #1 chkOe(1'b0);
        ctl.pins(1'b1, 1'b0, 1'b0);
        #1 chkOe(1'b1);
        ctl.cyc(SR, SEL, '0, 4'hF, 1'b0, '0);
        #1 chkData(pat(0));
        ctl.pins(1'b0, 1'b0, 1'b1);
        #1 chkData(pat(1));
        chkOe(1'b0);
        ctl.cyc(RD, SEL, 21'h22, 4'hF, 1'b0, '0);
        #1 chkOe(1'b1);
        ctl.cyc(RD, DES, '0, 4'hF, 1'b0, '0);
        #1 chkData(pat(2));
    endtask

    task automatic tSelect;
        ps = 1'b0;
        for (int c = 0; c < 8; c++) begin
            ctl.cyc(RD, 3'(c), 21'h20, 4'hF, 1'b0, '0);
            #1 chkOe(ps);
            ctl.cyc(RD, SEL, 21'h20, 4'hF, 1'b0, '0);
            #1 chkOe(3'(c) == SEL);
            ps = (3'(c) == SEL);
        end
        ctl.cyc(RD, DES, '0, 4'hF, 1'b0, '0);
        #1 chkOe(ps);
    endtask

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        rst = 1'b1;
        strap = 1'b0;
        err_total = 0;
        num_checks = 0;
        doReset(1'b0);
        tWriteRead();
        tBurst();
        tStall();
        tSelect();
        summarize();
    end
endmodule
